/* File: rtl/blink_cmd_defs.vh */
// Timing constants and command codes for the blinking-LED command decoder.
// Assumes a 200 MHz system clock; every count is derived from the period.
`ifndef BLINK_CMD_DEFS_VH
`define BLINK_CMD_DEFS_VH

`define CLK_PERIOD_NS 5
`define ENTER_TIME_US 500
`define ENTER_BLANK_TIME_US 1500
// Entering window, rounded up (least time)
`define ENTER_CYCLES ((`ENTER_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Window plus blank, rounded down (longest time)
`define ENTER_BLANK_CYCLES ((`ENTER_BLANK_TIME_US * 1000) / `CLK_PERIOD_NS)
`define BLANK_CYCLES (`ENTER_BLANK_CYCLES - `ENTER_CYCLES)

// Sequence step tick: 1 ms on-time resolution
`define TICK_TIME_US 1000
`define TICK_CYCLES ((`TICK_TIME_US * 1000) / `CLK_PERIOD_NS)

`define CMD_RUN 3'h1
`define CMD_TRAIN_START 3'h2
`define CMD_TRAIN_END 3'h3
`define CMD_RUN_ONCE 3'h4

`define SEQ_SLOTS 3
`define ON_W 8
`define OFF_W 8
// Off intervals are stored in 10 ms units of the 1 ms tick
`define OFF_SCALE 10

`endif

/* File: rtl/blink_player.v */
// Replays the stored on/off intervals, once or repeatedly.
// Assumes the caller holds start high for one cycle and stop aborts play.
module blink_player #(
  parameter TICK_CYCLES = 200000
) (
  input wire sys_clk,
  input wire rst,
  input wire start,
  input wire repeat_en,
  input wire stop,
  input wire [1:0] slot_count,
  input wire [23:0] on_times,
  input wire [23:0] off_times,
  output reg led_on,
  output reg busy,
  output reg done
);
  reg [31:0] tick_cnt_q;
  reg [11:0] step_q;
  reg [1:0] slot_q;
  reg phase_off_q;
  wire tick = (tick_cnt_q == TICK_CYCLES - 1);

  function [11:0] off_len;
    input [7:0] v;
    begin
      off_len = v * 12'd10;
    end
  endfunction

  always @(posedge sys_clk) begin
    done <= 1'b0;
    if (rst || stop) begin
      busy <= 1'b0;
      led_on <= 1'b0;
      tick_cnt_q <= 32'h0;
      step_q <= 12'h0;
      slot_q <= 2'h0;
      phase_off_q <= 1'b0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      led_on <= 1'b1;
      tick_cnt_q <= 32'h0;
      step_q <= 12'h0;
      slot_q <= 2'h0;
      phase_off_q <= 1'b0;
    end else if (busy) begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
      if (tick) begin
        step_q <= step_q + 12'h1;
        if (!phase_off_q && step_q + 12'h1 >= {4'h0, on_times[slot_q*8 +: 8]}) begin
          phase_off_q <= 1'b1;
          led_on <= 1'b0;
          step_q <= 12'h0;
        end else if (phase_off_q && step_q + 12'h1 >= off_len(off_times[slot_q*8 +: 8])) begin
          step_q <= 12'h0;
          phase_off_q <= 1'b0;
          if (slot_q + 2'h1 < slot_count) begin
            slot_q <= slot_q + 2'h1;
            led_on <= 1'b1;
          end else if (repeat_en) begin
            slot_q <= 2'h0;
            led_on <= 1'b1;
          end else begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end
endmodule // blink_player

/* File: rtl/led_blink_command_decoder.v */
// Mode state machine and single-wire command decoder of the LED driver.
// Assumes ctrl_in is asynchronous to sys_clk and rst is the power-on reset.
`include "blink_cmd_defs.vh"

module led_blink_command_decoder #(
  parameter ENTER_CYCLES = `ENTER_CYCLES,
  parameter BLANK_CYCLES = `BLANK_CYCLES,
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input wire sys_clk,
  input wire rst,
  input wire ctrl_in,
  output reg led_out,
  output reg active
);
  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam ST_STANDBY = 3'h0;
  localparam ST_ENTER = 3'h1;
  localparam ST_BLANK = 3'h2;
  localparam ST_WAIT_HIGH = 3'h3;
  localparam ST_RUN = 3'h4;
  localparam ST_RUN_ONCE = 3'h5;
  localparam ST_TRAIN = 3'h6;

  reg ctrl_meta_q, ctrl_sync_q, ctrl_prev_q;
  reg [2:0] state_q, state_d;
  reg [31:0] timer_q;
  reg [2:0] edges_q;
  reg [2:0] cmd_q;
  reg training_q;
  reg [1:0] slots_q;
  reg [23:0] on_q, off_q;
  reg [1:0] tslot_q;
  reg [1:0] tslots_q;
  reg tphase_off_q;
  reg [31:0] ttick_q;
  reg [11:0] tcnt_q;
  reg play_start_q;
  reg play_repeat_q;

  wire rise = ctrl_sync_q && !ctrl_prev_q;
  wire fall = !ctrl_sync_q && ctrl_prev_q;
  wire programmed = (slots_q != 2'h0);
  wire play_led, play_busy, play_done;
  wire play_stop = (state_q != ST_RUN) && (state_q != ST_RUN_ONCE);

  // Off intervals are kept in 10 ms units, saturating at the field's maximum
  function [7:0] off_code;
    input [11:0] t;
    reg [11:0] q;
    begin
      q = t / 12'ha;
      off_code = (q > 12'h0ff) ? 8'hff : q[7:0];
    end
  endfunction

  // ------------------------------------------------------------
  // Input synchroniser
  // ------------------------------------------------------------
  // Pin is asynchronous, so the first stage feeds no logic; edges come from the second and third stages
  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_meta_q <= 1'b0;
      ctrl_sync_q <= 1'b0;
      ctrl_prev_q <= 1'b0;
    end else begin
      ctrl_meta_q <= ctrl_in;
      ctrl_sync_q <= ctrl_meta_q;
      ctrl_prev_q <= ctrl_sync_q;
    end
  end

  // ------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY: begin
        if (rise)
          state_d = ST_ENTER;
      end
      ST_ENTER: begin
        if (timer_q == ENTER_CYCLES - 1)
          state_d = ST_BLANK;
      end
      ST_BLANK: begin
        if (timer_q == BLANK_CYCLES - 1) begin
          if (training_q && edges_q != `CMD_TRAIN_END)
            state_d = ST_TRAIN; // any edge count other than the end command is just the next on interval
          else if (edges_q == 3'h0 || edges_q > 3'h4)
            state_d = ST_STANDBY;
          else if (!ctrl_sync_q && edges_q == 3'h1)
            state_d = ST_STANDBY;
          else if (!ctrl_sync_q)
            state_d = ST_WAIT_HIGH;
          else
            state_d = ST_WAIT_HIGH; // dispatched next cycle
        end
      end
      ST_WAIT_HIGH: begin
        if (ctrl_sync_q) begin
          case (cmd_q)
            `CMD_RUN: state_d = ST_RUN;
            `CMD_TRAIN_START: state_d = ST_TRAIN;
            `CMD_TRAIN_END: state_d = ST_STANDBY;
            `CMD_RUN_ONCE: state_d = programmed ? ST_RUN_ONCE : ST_STANDBY;
            default: state_d = ST_STANDBY;
          endcase
        end
      end
      ST_RUN: begin
        if (!ctrl_sync_q)
          state_d = ST_STANDBY;
      end
      ST_RUN_ONCE: begin
        if (!ctrl_sync_q || play_done)
          state_d = ST_STANDBY;
      end
      ST_TRAIN: begin
        if (rise)
          state_d = ST_ENTER; // a new command may arrive
      end
      default: state_d = ST_STANDBY;
    endcase
  end

  // ------------------------------------------------------------
  // Timers, edge counter, sequence store
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    play_start_q <= 1'b0;
    if (rst) begin
      state_q <= ST_STANDBY;
      timer_q <= 32'h0;
      edges_q <= 3'h0;
      cmd_q <= 3'h0;
      training_q <= 1'b0;
      slots_q <= 2'h0;
      on_q <= 24'h0;
      off_q <= 24'h0;
      tslot_q <= 2'h0;
      tslots_q <= 2'h0;
      tphase_off_q <= 1'b0;
      ttick_q <= 32'h0;
      tcnt_q <= 12'h0;
      play_repeat_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= (state_d != state_q) ? 32'h0 : timer_q + 32'h1;
      if (state_q != ST_ENTER && state_d == ST_ENTER)
        edges_q <= 3'h1; // opening edge counts
      else if (state_q == ST_ENTER && rise && edges_q != 3'h7)
        edges_q <= edges_q + 3'h1;
      if (state_q == ST_BLANK && state_d == ST_WAIT_HIGH)
        cmd_q <= edges_q;
      if (state_q == ST_WAIT_HIGH && state_d == ST_TRAIN) begin
        training_q <= 1'b1;
        tslot_q <= 2'h0;
        tslots_q <= 2'h0;
        tphase_off_q <= 1'b0;
        ttick_q <= 32'h0;
        tcnt_q <= 12'h0;
      end
      if (state_q == ST_WAIT_HIGH && cmd_q == `CMD_TRAIN_END && ctrl_sync_q && training_q) begin
        // Opening rise already closed an off interval; an open on interval is dropped
        slots_q <= tslots_q;
        training_q <= 1'b0;
      end
      // Capture in 1 ms ticks while training, also while a window is open
      if (state_q == ST_TRAIN ||
          training_q && (state_q == ST_ENTER || state_q == ST_BLANK)) begin
        ttick_q <= (ttick_q == TICK_CYCLES - 1) ? 32'h0 : ttick_q + 32'h1;
        if (ttick_q == TICK_CYCLES - 1 && tcnt_q != 12'hfff)
          tcnt_q <= tcnt_q + 12'h1;
        if (fall && !tphase_off_q) begin
          on_q[tslot_q*8 +: 8] <= tcnt_q[11:8] == 4'h0 ? tcnt_q[7:0] : 8'hff;
          tphase_off_q <= 1'b1;
          tcnt_q <= 12'h0;
        end
        // Rises inside a window are command edges, not off-interval ends
        if (rise && tphase_off_q && state_q == ST_TRAIN) begin
          off_q[tslot_q*8 +: 8] <= off_code(tcnt_q);
          tslots_q <= tslot_q + 2'h1;
          if (tslot_q != 2'h2)
            tslot_q <= tslot_q + 2'h1;
          tphase_off_q <= 1'b0;
          tcnt_q <= 12'h0;
        end
      end
      if (state_d == ST_RUN_ONCE && state_q != ST_RUN_ONCE ||
          state_d == ST_RUN && state_q != ST_RUN && programmed) begin
        play_start_q <= 1'b1;
        play_repeat_q <= (state_d == ST_RUN);
      end
    end
  end

  blink_player #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_player (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(play_start_q),
    .repeat_en(play_repeat_q),
    .stop(play_stop),
    .slot_count(slots_q),
    .on_times(on_q),
    .off_times(off_q),
    .led_on(play_led),
    .busy(play_busy),
    .done(play_done)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      led_out <= 1'b0;
      active <= 1'b0;
    end else begin
      active <= (state_d != ST_STANDBY);
      case (state_d)
        ST_RUN: led_out <= programmed ? play_led : ctrl_sync_q;
        ST_RUN_ONCE: led_out <= play_led;
        ST_TRAIN: led_out <= ctrl_sync_q;
        ST_ENTER, ST_BLANK: led_out <= training_q && ctrl_sync_q;
        default: led_out <= 1'b0;
      endcase
    end
  end
endmodule // led_blink_command_decoder

/* File: dv/host_model.sv */
// Host side model: drives the single command pin.
// Assumes callers run on the same sys_clk as the decoder.
module host_model (
  input wire sys_clk,
  output logic ctrl_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ctrl_in = 1'b0;
  // Pin changes just after the edge, level held n cycles
  task automatic hold(input logic v, input int n);
    @(posedge sys_clk);
    #1 ctrl_in = v;
    repeat (n - 1) @(posedge sys_clk);
  endtask
  // Pulses fit inside the window; none follow until blank ends
  task automatic cmd(input int n, input logic keep);
    for (int i = 0; i < n; i++) begin
      hold(1'b1, 2);
      if (i < n - 1 || !keep) hold(1'b0, 2);
    end
  endtask
endmodule // host_model

/* File: dv/blink_cmd_props.sv */
// Checker for the LED command decoder, sees only its ports.
// Assumes the bench hands on the short counts through the bind.
module blink_cmd_props #(
  parameter ENTER_CYCLES = 20,
  parameter BLANK_CYCLES = 20,
  parameter TICK_CYCLES = 4
) (
  input wire sys_clk,
  input wire rst,
  input wire ctrl_in,
  input wire led_out,
  input wire active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] act_cnt_q;
  always @(posedge sys_clk) begin
    if (rst || !active) act_cnt_q <= 32'h0;
    else act_cnt_q <= act_cnt_q + 32'h1;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence idle_quiet;
    (!active && !ctrl_in) [*5];
  endsequence
  sequence pin_low;
    (!ctrl_in) [*6];
  endsequence
  rst_clear_a: assert property (disable iff (1'b0)
    rst |=> !active && !led_out) else $error("outputs not cleared by reset");
  standby_dark_a: assert property ((!active) [*3] |-> !led_out)
    else $error("led lit in standby");
  wake_up_a: assert property (!active && $rose(ctrl_in) |-> ##[1:6] active)
    else $error("rising edge did not wake");
  wake_cause_a: assert property ($rose(active) |-> $past(ctrl_in, 2) ||
    $past(ctrl_in, 3) || $past(ctrl_in, 4) || $past(ctrl_in, 5)) else $error("wake without edge");
  stay_idle_a: assert property (idle_quiet |=> !active)
    else $error("left standby without edge");
  window_min_a: assert property ($fell(active) |-> act_cnt_q >= ENTER_CYCLES)
    else $error("window closed early");
  led_dark_a: assert property (pin_low |-> !led_out)
    else $error("led lit with pin low");
  led_cause_a: assert property ($rose(led_out) |-> active && $past(ctrl_in, 3))
    else $error("led rose without pin high");
endmodule // blink_cmd_props

bind led_blink_command_decoder blink_cmd_props #(
  .ENTER_CYCLES(ENTER_CYCLES),
  .BLANK_CYCLES(BLANK_CYCLES),
  .TICK_CYCLES(TICK_CYCLES)
) props (
  .sys_clk(sys_clk),
  .rst(rst),
  .ctrl_in(ctrl_in),
  .led_out(led_out),
  .active(active)
);

/* File: dv/testbench.sv */
// Self-checking bench for the LED command decoder.
// Assumes short window, blank and tick counts; host model drives the pin.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int E = 20;
  localparam int B = 20;
  // Margin covers the synchroniser lag
  localparam int SETTLE = E + B + 10;
  logic sys_clk;
  logic rst;
  wire ctrl_in;
  wire led_out;
  wire active;
  int error_cnt;
  int compares;
  int cycles;
  int hi;
  int lo;
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  led_blink_command_decoder #(.ENTER_CYCLES(E), .BLANK_CYCLES(B), .TICK_CYCLES(4)) dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .ctrl_in(ctrl_in),
    .led_out(led_out),
    .active(active)
  );
  host_model host (
    .sys_clk(sys_clk),
    .ctrl_in(ctrl_in)
  );
  task automatic check(input string what, input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("Compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Ends on a falling edge so outputs are settled
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic sample(input int n);
    hi = 0;
    lo = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (led_out === 1'b1) hi++;
      else lo++;
    end
  endtask
  task automatic t_run_plain;
    host.cmd(1, 1'b1);
    wait_n(8);
    check("active", active, 1'b1);
    check("led_window", led_out, 1'b0);
    wait_n(SETTLE);
    check("led_run", led_out, 1'b1);
    host.hold(1'b0, 8);
    wait_n(0);
    check("led_off", led_out, 1'b0);
    check("standby", active, 1'b0);
  endtask
  task automatic t_bad;
    host.cmd(5, 1'b1);
    wait_n(SETTLE);
    check("bad_count", active, 1'b0);
    host.hold(1'b0, 4);
  endtask
  task automatic t_train;
    host.cmd(2, 1'b1);
    wait_n(SETTLE);
    host.hold(1'b0, 20);
    wait_n(0);
    check("train_low", led_out, 1'b0);
    host.hold(1'b1, 12);
    wait_n(0);
    check("train_high", led_out, 1'b1);
    host.hold(1'b0, 80);
    host.cmd(3, 1'b1);
    wait_n(SETTLE);
    check("train_end", active, 1'b0);
    host.hold(1'b0, 4);
  endtask
  task automatic t_run_prog;
    host.cmd(1, 1'b1);
    wait_n(SETTLE);
    sample(200);
    check("seq_on", hi > 0, 1'b1);
    check("seq_off", lo > 0, 1'b1);
    sample(200);
    check("seq_again", hi > 0, 1'b1);
    host.hold(1'b0, 8);
    wait_n(0);
    check("prog_stop", active, 1'b0);
  endtask
  task automatic t_once_defer;
    host.cmd(4, 1'b0);
    wait_n(SETTLE);
    check("defer_dark", led_out, 1'b0);
    host.hold(1'b1, 1);
    sample(30);
    check("defer_play", hi > 0, 1'b1);
    wait_n(300);
    check("once_end", active, 1'b0);
    host.hold(1'b0, 4);
  endtask
  task automatic t_abort;
    host.cmd(4, 1'b1);
    wait_n(SETTLE);
    host.hold(1'b0, 6);
    wait_n(0);
    check("abort", active, 1'b0);
  endtask
  task automatic t_reset_mid;
    host.cmd(1, 1'b1);
    wait_n(8);
    rst = 1'b1;
    host.hold(1'b0, 2);
    wait_n(0);
    check("rst_active", active, 1'b0);
    check("rst_led", led_out, 1'b0);
    #1 rst = 1'b0;
    host.cmd(4, 1'b1);
    wait_n(SETTLE);
    check("seq_cleared", active, 1'b0);
    host.hold(1'b0, 4);
  endtask
  initial begin
    rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 rst = 1'b0;
    wait_n(10);
    check("idle", active, 1'b0);
    check("idle_led", led_out, 1'b0);
    t_run_plain;
    t_bad;
    t_train;
    t_run_prog;
    t_once_defer;
    t_abort;
    t_reset_mid;
    stop_test;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      stop_test;
    end
  end
endmodule // testbench
